// ===== design/ilca_pkg.sv
package ilca_pkg;

  // ********************************************************
  // Widths and register map
  // ********************************************************
  localparam int DATA_W    = 16;
  localparam int ADDR_W    = 5;
  localparam int KEY_WORDS = 8;
  localparam int ALARM_W   = 13;

  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_SHUTOFF = 5'h01;
  localparam logic [ADDR_W-1:0] ADDR_MASK    = 5'h02;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 5'h03;
  localparam logic [ADDR_W-1:0] ADDR_ERRMAP  = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_KEY0    = 5'h08;

  // ********************************************************
  // Control register fields
  // ********************************************************
  localparam int CTRL_TEST_EN   = 0;
  localparam int CTRL_WORD_PAR  = 1;
  localparam int CTRL_BLOCK_PAR = 2;
  localparam int CTRL_ODD_SENSE = 3;
  localparam int CTRL_SW_TX     = 4;
  localparam int CTRL_SYNC_LO   = 8;
  localparam int SYNC_SEL_W     = 5;
  localparam int SYNC_SEL_FRAME = 0;
  localparam int SYNC_SEL_SYNC  = 1;

  // Auto shut-off fields
  localparam int SHUT_CLOCK     = 0;
  localparam int SHUT_COLLISION = 1;

  // ********************************************************
  // Alarm status bit positions
  // ********************************************************
  localparam int ST_ZERO_PTR     = 0;
  localparam int ST_FIFO_ANY     = 1;
  localparam int ST_TWO_APART    = 2;
  localparam int ST_ONE_APART    = 3;
  localparam int ST_COLLISION    = 4;
  localparam int ST_SAMPLE_GONE  = 5;
  localparam int ST_STROBE_GONE  = 6;
  localparam int ST_PATTERN      = 7;
  localparam int ST_PLL          = 8;
  localparam int ST_RISE_PARITY  = 9;
  localparam int ST_FALL_PARITY  = 10;
  localparam int ST_BLOCK_PARITY = 11;
  localparam int ST_CLOCK_GONE   = 12;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [DATA_W-1:0]  CTRL_RESET    = 16'h0010;
  localparam logic [DATA_W-1:0]  SHUTOFF_RESET = 16'h0000;
  localparam logic [ALARM_W-1:0] MASK_RESET    = 13'h1FFF;
  localparam logic [DATA_W-1:0]  KEY_RESET     = 16'h7A7A;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_MHZ        = 250;
  localparam int STROBE_LOSS_NS = 200;
  localparam int SAMPLE_LOSS_NS = 200;
  localparam int STROBE_LOSS_CYC = (STROBE_LOSS_NS * CLK_MHZ + 999) / 1000;
  localparam int SAMPLE_LOSS_CYC = (SAMPLE_LOSS_NS * CLK_MHZ + 999) / 1000;
  localparam int LOSS_CNT_W      = 8;

  // ********************************************************
  // Types
  // ********************************************************
  typedef struct packed {
    logic [DATA_W-1:0] dataLanes;
    logic              parityLane;
    logic              frameMarker;
    logic              syncMarker;
    logic              wordStrobe;
    logic              sampleClk;
  } ilca_pins_t;

  typedef enum logic [1:0] {
    CHK_IDLE = 2'b00,
    CHK_HUNT = 2'b01,
    CHK_RUN  = 2'b10
  } ilca_chk_state_t;

endpackage

// ===== design/ilca_top.sv
// Operation
// - Test enable forces analog outputs off regardless of gate pin or software enable.
// - Key is eight 16-bit words, each in its own writable register.
// - Selected marker rising edge starts frame; source presents key word zero there.
// - Only first marker edge aligns; later repetitions checked without markers.
// - Each mismatching data lane sets its bit in the 16-bit error map.
// - Any mismatch sets pattern alarm, status bit 7; only valid alarm in test.
// - Writing zero clears error map and alarm; persisting errors set again.
// - Word parity: ones of 16 lanes plus parity lane odd/even per sense.
// - Rising and falling edge words have separate parity alarm bits.
// - Frame marker rise at a rising strobe closes one block, opens next.
// - Frame level at following falling strobe gives expected block parity.
// - Block ones count disagreeing with expected parity sets block parity alarm.
// - Alarms show in status and masked on pin; sticky until software clears.
// - All-zero one-hot write pointer raises pointer-zero alarm.
// - Pointers within two, within one, equal raise own alarms plus combined alarm.
// - Sample clock lost, strobe lost, and combined clock-lost alarms.
// - PLL alarm raised whenever clock multiplier loses lock.
// - Enabled clock-lost and collision alarms shut outputs off, overriding enables.
// - Mask register chooses which alarms may drive the alarm pin.
// - Sync source select also picks the marker that resets FIFO write pointer.
module ilca_top
  import ilca_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  clkEn,
  // Register port
  input  wire logic [ADDR_W-1:0]     regAddr,
  input  wire logic [DATA_W-1:0]     regWrData,
  input  wire logic                  regWrStrobe,
  input  wire logic                  regRdStrobe,
  output logic      [DATA_W-1:0]     regRdData,
  // Link pins
  input  ilca_pins_t                 linkPins,
  // Device monitors
  input  wire logic [FIFO_DEPTH-1:0] fifoWrPtr,
  input  wire logic [FIFO_DEPTH-1:0] fifoRdPtr,
  input  wire logic                  pllLocked,
  input  wire logic                  txGatePin,
  // Results
  output logic                       alarmPin,
  output logic                       outputsEnable,
  output logic                       fifoSyncPulse
);

  localparam int IDX_W = $clog2(FIFO_DEPTH);
  localparam logic [IDX_W-1:0] ONE_APART = IDX_W'(1);
  localparam logic [IDX_W-1:0] TWO_APART = IDX_W'(2);

  // ********************************************************
  // Functions
  // ********************************************************
  function automatic logic [IDX_W-1:0] ptrIdx(input logic [FIFO_DEPTH-1:0] ptr);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      if (ptr[i]) begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic withinDist(input logic [IDX_W-1:0] d,
                                      input logic [IDX_W-1:0] lim);
    logic [IDX_W-1:0] negD;
    negD = IDX_W'(-d);
    return (d <= lim) || (negD <= lim);
  endfunction

  // ********************************************************
  // Synchronisers
  // ********************************************************
  ilca_pins_t                  pinsS1;
  ilca_pins_t                  pinsS2;
  ilca_pins_t                  pinsS3;
  logic [FIFO_DEPTH-1:0]       wrPtrS1;
  logic [FIFO_DEPTH-1:0]       wrPtrS2;
  logic [FIFO_DEPTH-1:0]       rdPtrS1;
  logic [FIFO_DEPTH-1:0]       rdPtrS2;
  logic [1:0]                  pllS;
  logic [1:0]                  gateS;

  // Pointers are assumed quasi-static when sampled; a skewed one-hot word
  // can raise a spurious near-collision alarm for one cycle.
  always_ff @(posedge clk) begin
    if (srst) begin
      pinsS1  <= '0;
      pinsS2  <= '0;
      pinsS3  <= '0;
      wrPtrS1 <= '0;
      wrPtrS2 <= '0;
      rdPtrS1 <= '0;
      rdPtrS2 <= '0;
      pllS    <= 2'h0;
      gateS   <= 2'h0;
    end else if (clkEn) begin
      pinsS1  <= linkPins;
      pinsS2  <= pinsS1;
      pinsS3  <= pinsS2;
      wrPtrS1 <= fifoWrPtr;
      wrPtrS2 <= wrPtrS1;
      rdPtrS1 <= fifoRdPtr;
      rdPtrS2 <= rdPtrS1;
      pllS    <= {pllS[0], pllLocked};
      gateS   <= {gateS[0], txGatePin};
    end
  end

  // ********************************************************
  // State
  // ********************************************************
  logic [DATA_W-1:0]     ctrl_reg,       ctrl_next;
  logic [DATA_W-1:0]     shutoff_reg,    shutoff_next;
  logic [ALARM_W-1:0]    mask_reg,       mask_next;
  logic [ALARM_W-1:0]    status_reg,     status_next;
  logic [DATA_W-1:0]     errMap_reg,     errMap_next;
  logic [DATA_W-1:0]     key_reg         [KEY_WORDS];
  logic [DATA_W-1:0]     key_next        [KEY_WORDS];
  logic [DATA_W-1:0]     rdData_reg,     rdData_next;
  ilca_chk_state_t       chk_reg,        chk_next;
  logic [2:0]            keyIdx_reg,     keyIdx_next;
  logic                  markerPrev_reg, markerPrev_next;
  logic                  frameRise_reg,  frameRise_next;
  logic                  blockAcc_reg,   blockAcc_next;
  logic                  blockPend_reg,  blockPend_next;
  logic                  blockOpen_reg,  blockOpen_next;
  logic                  awaitFall_reg,  awaitFall_next;
  logic [LOSS_CNT_W-1:0] strobeCnt_reg,  strobeCnt_next;
  logic [LOSS_CNT_W-1:0] sampleCnt_reg,  sampleCnt_next;
  logic                  alarm_reg,      alarm_next;
  logic                  outEn_reg,      outEn_next;
  logic                  syncPulse_reg,  syncPulse_next;

  // ********************************************************
  // Next-state logic
  // ********************************************************
  logic                   strobeRise;
  logic                   strobeFall;
  logic                   strobeEdge;
  logic [DATA_W-1:0]      word;
  logic [SYNC_SEL_W-1:0]  syncSel;
  logic                   markerNow;
  logic                   markerRise;
  logic                   frameBoundary;
  logic                   wordOnes;
  logic [DATA_W-1:0]      errSet;
  logic [ALARM_W-1:0]     alarmSet;
  logic [IDX_W-1:0]       ptrDist;
  logic                   autoShut;

  always_comb begin
    strobeRise    = pinsS2.wordStrobe & ~pinsS3.wordStrobe;
    strobeFall    = ~pinsS2.wordStrobe & pinsS3.wordStrobe;
    strobeEdge    = strobeRise | strobeFall;
    word          = pinsS2.dataLanes;
    wordOnes      = ^word;
    syncSel       = ctrl_reg[CTRL_SYNC_LO +: SYNC_SEL_W];
    markerNow     = (syncSel[SYNC_SEL_FRAME] & pinsS2.frameMarker)
                  | (syncSel[SYNC_SEL_SYNC] & pinsS2.syncMarker);
    markerRise    = strobeEdge & markerNow & ~markerPrev_reg;
    frameBoundary = strobeRise & pinsS2.frameMarker & ~frameRise_reg;
    errSet        = '0;
    alarmSet      = '0;

    ctrl_next       = ctrl_reg;
    shutoff_next    = shutoff_reg;
    mask_next       = mask_reg;
    key_next        = key_reg;
    chk_next        = chk_reg;
    keyIdx_next     = keyIdx_reg;
    markerPrev_next = strobeEdge ? markerNow : markerPrev_reg;
    frameRise_next  = strobeRise ? pinsS2.frameMarker : frameRise_reg;
    blockAcc_next   = blockAcc_reg;
    blockPend_next  = blockPend_reg;
    blockOpen_next  = blockOpen_reg;
    awaitFall_next  = awaitFall_reg;
    syncPulse_next  = markerRise;

    // Pattern checker
    case (chk_reg)
      CHK_IDLE: begin
        if (ctrl_reg[CTRL_TEST_EN]) begin
          chk_next = CHK_HUNT;
        end
      end
      CHK_HUNT: begin
        if (!ctrl_reg[CTRL_TEST_EN]) begin
          chk_next = CHK_IDLE;
        end else if (markerRise) begin
          errSet      = word ^ key_reg[0];
          keyIdx_next = 3'h1;
          chk_next    = CHK_RUN;
        end
      end
      CHK_RUN: begin
        if (!ctrl_reg[CTRL_TEST_EN]) begin
          chk_next = CHK_IDLE;
        end else if (strobeEdge) begin
          // Later markers are ignored; the index simply wraps
          errSet      = word ^ key_reg[keyIdx_reg];
          keyIdx_next = keyIdx_reg + 3'h1;
        end
      end
      default: begin
        chk_next = CHK_IDLE;
      end
    endcase
    alarmSet[ST_PATTERN] = |errSet;

    // Word parity, checked per edge
    if (ctrl_reg[CTRL_WORD_PAR] && strobeEdge) begin
      if ((wordOnes ^ pinsS2.parityLane) != ctrl_reg[CTRL_ODD_SENSE]) begin
        alarmSet[ST_RISE_PARITY] = strobeRise;
        alarmSet[ST_FALL_PARITY] = strobeFall;
      end
    end

    // Block parity
    if (!ctrl_reg[CTRL_BLOCK_PAR]) begin
      blockOpen_next = 1'b0;
      awaitFall_next = 1'b0;
    end else begin
      if (strobeRise) begin
        if (frameBoundary) begin
          blockPend_next = blockAcc_reg;
          awaitFall_next = blockOpen_reg;
          blockOpen_next = 1'b1;
          blockAcc_next  = wordOnes;
        end else begin
          blockAcc_next  = blockAcc_reg ^ wordOnes;
        end
      end
      if (strobeFall) begin
        blockAcc_next = blockAcc_reg ^ wordOnes;
        if (awaitFall_reg) begin
          awaitFall_next = 1'b0;
          alarmSet[ST_BLOCK_PARITY] = blockPend_reg != pinsS2.frameMarker;
        end
      end
    end

    // Clock-loss watchdogs saturate at their timeout
    strobeCnt_next = (pinsS2.wordStrobe != pinsS3.wordStrobe) ? '0 :
                     (strobeCnt_reg == LOSS_CNT_W'(STROBE_LOSS_CYC)) ? strobeCnt_reg :
                     strobeCnt_reg + 1'b1;
    sampleCnt_next = (pinsS2.sampleClk != pinsS3.sampleClk) ? '0 :
                     (sampleCnt_reg == LOSS_CNT_W'(SAMPLE_LOSS_CYC)) ? sampleCnt_reg :
                     sampleCnt_reg + 1'b1;
    alarmSet[ST_STROBE_GONE] = strobeCnt_reg == LOSS_CNT_W'(STROBE_LOSS_CYC);
    alarmSet[ST_SAMPLE_GONE] = sampleCnt_reg == LOSS_CNT_W'(SAMPLE_LOSS_CYC);
    alarmSet[ST_CLOCK_GONE]  = alarmSet[ST_STROBE_GONE] | alarmSet[ST_SAMPLE_GONE];

    // FIFO pointer monitors
    ptrDist = ptrIdx(wrPtrS2) - ptrIdx(rdPtrS2);
    alarmSet[ST_ZERO_PTR]  = wrPtrS2 == '0;
    alarmSet[ST_COLLISION] = (wrPtrS2 != '0) && (ptrDist == '0);
    alarmSet[ST_ONE_APART] = (wrPtrS2 != '0) && withinDist(ptrDist, ONE_APART);
    alarmSet[ST_TWO_APART] = (wrPtrS2 != '0) && withinDist(ptrDist, TWO_APART);
    alarmSet[ST_FIFO_ANY]  = alarmSet[ST_COLLISION] | alarmSet[ST_ONE_APART]
                           | alarmSet[ST_TWO_APART];
    alarmSet[ST_PLL]       = ~pllS[1];

    // Register writes; a set in the clearing cycle wins
    status_next = status_reg;
    errMap_next = errMap_reg;
    if (regWrStrobe) begin
      case (regAddr)
        ADDR_CTRL:    ctrl_next    = regWrData;
        ADDR_SHUTOFF: shutoff_next = regWrData;
        ADDR_MASK:    mask_next    = regWrData[ALARM_W-1:0];
        ADDR_STATUS:  status_next  = status_reg & regWrData[ALARM_W-1:0];
        ADDR_ERRMAP:  errMap_next  = errMap_reg & regWrData;
        default: ;
      endcase
      for (int k = 0; k < KEY_WORDS; k++) begin
        if (regAddr == ADDR_KEY0 + ADDR_W'(k)) begin
          key_next[k] = regWrData;
        end
      end
    end
    status_next = status_next | alarmSet;
    errMap_next = errMap_next | errSet;

    // Register reads
    rdData_next = '0;
    if (regRdStrobe) begin
      case (regAddr)
        ADDR_CTRL:    rdData_next = ctrl_reg;
        ADDR_SHUTOFF: rdData_next = shutoff_reg;
        ADDR_MASK:    rdData_next = DATA_W'(mask_reg);
        ADDR_STATUS:  rdData_next = DATA_W'(status_reg);
        ADDR_ERRMAP:  rdData_next = errMap_reg;
        default:      rdData_next = '0;
      endcase
      if (regAddr >= ADDR_KEY0 && regAddr < ADDR_KEY0 + ADDR_W'(KEY_WORDS)) begin
        rdData_next = key_reg[regAddr[2:0]];
      end
    end

    // Output control from sticky status, so shut-off holds until cleared
    autoShut = (shutoff_next[SHUT_CLOCK] & status_next[ST_CLOCK_GONE])
             | (shutoff_next[SHUT_COLLISION] & status_next[ST_COLLISION]);
    outEn_next = gateS[1] & ctrl_next[CTRL_SW_TX] & ~ctrl_next[CTRL_TEST_EN]
               & ~autoShut;
    alarm_next = |(status_next & ~mask_next);
  end

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg       <= CTRL_RESET;
      shutoff_reg    <= SHUTOFF_RESET;
      mask_reg       <= MASK_RESET;
      status_reg     <= '0;
      errMap_reg     <= '0;
      for (int k = 0; k < KEY_WORDS; k++) begin
        key_reg[k] <= KEY_RESET;
      end
      rdData_reg     <= '0;
      chk_reg        <= CHK_IDLE;
      keyIdx_reg     <= 3'h0;
      markerPrev_reg <= 1'b0;
      frameRise_reg  <= 1'b0;
      blockAcc_reg   <= 1'b0;
      blockPend_reg  <= 1'b0;
      blockOpen_reg  <= 1'b0;
      awaitFall_reg  <= 1'b0;
      strobeCnt_reg  <= '0;
      sampleCnt_reg  <= '0;
      alarm_reg      <= 1'b0;
      outEn_reg      <= 1'b0;
      syncPulse_reg  <= 1'b0;
    end else if (clkEn) begin
      ctrl_reg       <= ctrl_next;
      shutoff_reg    <= shutoff_next;
      mask_reg       <= mask_next;
      status_reg     <= status_next;
      errMap_reg     <= errMap_next;
      key_reg        <= key_next;
      rdData_reg     <= rdData_next;
      chk_reg        <= chk_next;
      keyIdx_reg     <= keyIdx_next;
      markerPrev_reg <= markerPrev_next;
      frameRise_reg  <= frameRise_next;
      blockAcc_reg   <= blockAcc_next;
      blockPend_reg  <= blockPend_next;
      blockOpen_reg  <= blockOpen_next;
      awaitFall_reg  <= awaitFall_next;
      strobeCnt_reg  <= strobeCnt_next;
      sampleCnt_reg  <= sampleCnt_next;
      alarm_reg      <= alarm_next;
      outEn_reg      <= outEn_next;
      syncPulse_reg  <= syncPulse_next;
    end
  end

  assign regRdData     = rdData_reg;
  assign alarmPin      = alarm_reg;
  assign outputsEnable = outEn_reg;
  assign fifoSyncPulse = syncPulse_reg;

endmodule

// ===== verification/ilca_props.sv
module ilca_props
  import ilca_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  srst,
  // Register port
  input wire logic [ADDR_W-1:0]     regAddr,
  input wire logic [DATA_W-1:0]     regWrData,
  input wire logic                  regWrStrobe,
  input wire logic                  regRdStrobe,
  input wire logic [DATA_W-1:0]     regRdData,
  // Monitors and results
  input wire logic [FIFO_DEPTH-1:0] fifoWrPtr,
  input wire logic [FIFO_DEPTH-1:0] fifoRdPtr,
  input wire logic                  pllLocked,
  input wire logic                  alarmPin,
  input wire logic                  outputsEnable,
  input wire logic                  fifoSyncPulse
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************
  // Register shadows
  // ****************
  logic [DATA_W-1:0]  ctrl_reg, ctrl_next, shut_reg, shut_next, rdKey_reg, rdKey_next;
  logic [ALARM_W-1:0] mask_reg, mask_next;
  logic [DATA_W-1:0]  key_reg  [KEY_WORDS];
  logic [DATA_W-1:0]  key_next [KEY_WORDS];

  always_comb begin
    ctrl_next  = ctrl_reg;
    shut_next  = shut_reg;
    mask_next  = mask_reg;
    key_next   = key_reg;
    rdKey_next = key_reg[regAddr[2:0]];
    if (regWrStrobe) begin
      case (regAddr)
        ADDR_CTRL:    ctrl_next = regWrData;
        ADDR_SHUTOFF: shut_next = regWrData;
        ADDR_MASK:    mask_next = regWrData[ALARM_W-1:0];
        default:      if (regAddr[4:3] == 2'b01) key_next[regAddr[2:0]] = regWrData;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg  <= CTRL_RESET;
      shut_reg  <= SHUTOFF_RESET;
      mask_reg  <= MASK_RESET;
      key_reg   <= '{default: KEY_RESET};
      rdKey_reg <= 16'h0000;
    end else begin
      ctrl_reg  <= ctrl_next;
      shut_reg  <= shut_next;
      mask_reg  <= mask_next;
      key_reg   <= key_next;
      rdKey_reg <= rdKey_next;
    end
  end

  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_TEST_OFF: assert property (ctrl_reg[CTRL_TEST_EN] |-> !outputsEnable)
    else $error("outputs active in test mode");
  AST_KEY_READ: assert property (regRdStrobe && regAddr[4:3] == 2'b01
    |=> regRdData == rdKey_reg) else $error("key read wrong");
  AST_MASK_ALL: assert property (mask_reg == {ALARM_W{1'b1}} |-> !alarmPin)
    else $error("alarm pin with all masked");
  AST_SYNC_PULSE: assert property (fifoSyncPulse |=> !fifoSyncPulse)
    else $error("sync pulse too long");
  AST_SYNC_SEL: assert property (fifoSyncPulse
    |-> ctrl_reg[CTRL_SYNC_LO +: SYNC_SEL_W] != 5'h00) else $error("sync with no marker");
  AST_PIN_STICKY: assert property ($fell(alarmPin) |-> $past(regWrStrobe) &&
    ($past(regAddr) == ADDR_MASK || $past(regAddr) == ADDR_STATUS))
    else $error("alarm pin dropped by itself");
  AST_PLL_PIN: assert property ((!mask_reg[ST_PLL] && !pllLocked) [*6] |-> alarmPin)
    else $error("lock loss not on pin");
  AST_SHUT_COLL: assert property ((shut_reg[SHUT_COLLISION] && fifoWrPtr == fifoRdPtr
    && fifoWrPtr != '0) [*6] |-> !outputsEnable) else $error("collision did not shut off");
endmodule

bind ilca_top ilca_props #(.FIFO_DEPTH(FIFO_DEPTH)) props (
  .clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
  .fifoWrPtr(fifoWrPtr), .fifoRdPtr(fifoRdPtr), .pllLocked(pllLocked),
  .alarmPin(alarmPin), .outputsEnable(outputsEnable), .fifoSyncPulse(fifoSyncPulse));

// ===== verification/ilca_source.sv
module ilca_source
  import ilca_pkg::*;
(
  // Control from the bench
  input  wire logic              run,
  input  wire logic [DATA_W-1:0] keys [KEY_WORDS],
  input  wire logic [DATA_W-1:0] flip,
  input  wire logic              oddSense,
  input  wire logic              badFall,
  input  wire logic              blkBad,
  input  wire logic              sclkRun,
  input  wire logic [7:0]        blkLen,
  // Link pins
  output ilca_pins_t             pins
);
  timeunit 1ns;
  timeprecision 100ps;
  int                n;
  logic [DATA_W-1:0] w;
  logic              acc, prev, rise;

  // Strobe stops low between runs, so word zero meets a rise
  initial begin
    pins = '0;
    fork
      forever #10 if (sclkRun) pins.sampleClk = ~pins.sampleClk;
    join_none
    #1.3;
    forever begin
      wait (run);
      n = 0;
      while (run || pins.wordStrobe) begin
        rise = !pins.wordStrobe;
        w = keys[n % KEY_WORDS] ^ ((n % KEY_WORDS == 3) ? flip : 16'h0000);
        pins.dataLanes  = w;
        pins.parityLane = ^w ^ oddSense ^ (badFall && !rise);
        if (n == 0 || (blkLen != 0 && n % blkLen == 0)) begin
          prev = acc;
          acc  = ^w;
          pins.frameMarker = 1'b1;
        end else begin
          acc = acc ^ (^w);
          pins.frameMarker = (n > 1 && blkLen != 0 && n % blkLen == 1) ? prev ^ blkBad : 1'b0;
        end
        #8;
        pins.wordStrobe = rise;
        #8;
        n++;
      end
      pins.dataLanes   = ~w;
      pins.parityLane  = ~pins.parityLane;
      pins.frameMarker = 1'b0;
    end
  end

endmodule

// ===== verification/tb_input_link_checker_alarms.sv
module tb_input_link_checker_alarms
  import ilca_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    string             nm;
    logic [DATA_W-1:0] m;
    logic [DATA_W-1:0] e;
  } ilca_note_t;

  logic              clk, srst, clkEn, regWrStrobe, regRdStrobe, pllLocked, txGatePin, rdWas;
  logic              alarmPin, outputsEnable, fifoSyncPulse, run, oddSense, badFall, blkBad, sclkRun;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData, flip, f;
  logic [DATA_W-1:0] keys [KEY_WORDS];
  logic [DATA_W-1:0] fifoExp [4] = '{16'h001E, 16'h000E, 16'h0006, 16'h0000};
  logic [7:0]        fifoWrPtr, fifoRdPtr, blkLen;
  ilca_pins_t        linkPins;
  ilca_note_t        notes[$];
  ilca_note_t        n;
  int                errCount, checked, seed, i;

  ilca_top #(.FIFO_DEPTH(8)) DUT (
    .clk(clk), .srst(srst), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .linkPins(linkPins), .fifoWrPtr(fifoWrPtr), .fifoRdPtr(fifoRdPtr), .pllLocked(pllLocked),
    .txGatePin(txGatePin), .alarmPin(alarmPin), .outputsEnable(outputsEnable),
    .fifoSyncPulse(fifoSyncPulse));
  ilca_source src (
    .run(run), .keys(keys), .flip(flip), .oddSense(oddSense), .badFall(badFall),
    .blkBad(blkBad), .sclkRun(sclkRun), .blkLen(blkLen), .pins(linkPins));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  task automatic chk(input string nm, input logic [DATA_W-1:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic endOfTest();
    $display("checks %0d errors %0d", checked, errCount);
    if (errCount == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Changes land right after an edge, so back-to-back strobes never collide
  task automatic bus(input logic w, r, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    regWrStrobe <= w;
    regRdStrobe <= r;
    regAddr     <= a;
    regWrData   <= d;
  endtask

  task automatic idle(input int c);
    repeat (c) bus(1'b0, 1'b0, 5'h00, 16'h0000);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, e, input string nm);
    notes.push_back('{nm, m, e});
    bus(1'b0, 1'b1, a, 16'h0000);
  endtask

  // A settle before clearing drops errors from link changes
  task automatic soak(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, e, input string nm);
    idle(100);
    wr(ADDR_STATUS, 16'h0000);
    wr(ADDR_ERRMAP, 16'h0000);
    idle(100);
    rd(a, m, e, nm);
  endtask

  always @(posedge clk) begin
    if (rdWas) begin
      n = notes.pop_front();
      chk(n.nm, regRdData & n.m, n.e);
    end
    rdWas <= regRdStrobe;
  end

  initial begin
    #400000;
    errCount++;
    endOfTest();
  end

  initial begin
    seed = 32'h2E65;
    {srst, clkEn, txGatePin, pllLocked, sclkRun} = 5'h1F;
    {regWrStrobe, regRdStrobe, run, oddSense, badFall, blkBad, rdWas} = 7'h00;
    {regAddr, regWrData, flip, blkLen} = '0;
    fifoWrPtr = 8'h01;
    fifoRdPtr = 8'h10;
    for (i = 0; i < KEY_WORDS; i++) keys[i] = 16'h7A7A;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rd(ADDR_CTRL, 16'hFFFF, 16'h0010, "ctrl");
    rd(ADDR_MASK, 16'hFFFF, 16'h1FFF, "mask");
    rd(ADDR_SHUTOFF, 16'hFFFF, 16'h0000, "shutoff");
    rd(5'h1F, 16'hFFFF, 16'h0000, "unmapped");
    for (i = 0; i < KEY_WORDS; i++) begin
      rd(5'(ADDR_KEY0 + i), 16'hFFFF, 16'h7A7A, "keyReset");
      keys[i] = 16'($random(seed));
      wr(5'(ADDR_KEY0 + i), keys[i]);
    end
    for (i = 0; i < KEY_WORDS; i++) rd(5'(ADDR_KEY0 + i), 16'hFFFF, keys[i], "key");
    idle(4);
    chk("outputsEnable", {15'h0, outputsEnable}, 16'h0001);
    wr(ADDR_CTRL, 16'h0111);
    idle(2);
    chk("outputsEnable", {15'h0, outputsEnable}, 16'h0000);
    run <= 1'b1;
    for (i = 0; i < 200 && fifoSyncPulse !== 1'b1; i++) idle(1);
    chk("syncPulse", 16'(i < 200), 16'h0001);
    idle(3200);
    soak(ADDR_ERRMAP, 16'hFFFF, 16'h0000, "errmapClean");
    rd(ADDR_STATUS, 16'h0080, 16'h0000, "patternClean");
    f = 16'($random(seed)) | 16'h0001;
    flip <= f;
    soak(ADDR_ERRMAP, 16'hFFFF, f, "errmapBits");
    rd(ADDR_STATUS, 16'h0080, 16'h0080, "patternAlarm");
    wr(ADDR_MASK, 16'h1F7F);
    idle(2);
    chk("alarmPin", {15'h0, alarmPin}, 16'h0001);
    flip <= 16'h0000;
    soak(ADDR_ERRMAP, 16'hFFFF, 16'h0000, "errmapCleared");
    rd(ADDR_STATUS, 16'h0080, 16'h0000, "patternCleared");
    idle(2);
    chk("alarmPin", {15'h0, alarmPin}, 16'h0000);
    wr(ADDR_CTRL, 16'h001A);
    oddSense <= 1'b1;
    soak(ADDR_STATUS, 16'h0600, 16'h0000, "oddParity");
    badFall <= 1'b1;
    soak(ADDR_STATUS, 16'h0600, 16'h0400, "fallParity");
    badFall <= 1'b0;
    oddSense <= 1'b0;
    wr(ADDR_CTRL, 16'h0012);
    soak(ADDR_STATUS, 16'h0600, 16'h0000, "evenParity");
    run <= 1'b0;
    idle(20);
    wr(ADDR_CTRL, 16'h0014);
    blkLen <= 8'h10;
    run <= 1'b1;
    soak(ADDR_STATUS, 16'h0800, 16'h0000, "blockGood");
    blkBad <= 1'b1;
    soak(ADDR_STATUS, 16'h0800, 16'h0800, "blockBad");
    wr(ADDR_MASK, 16'h1EFF);
    pllLocked <= 1'b0;
    soak(ADDR_STATUS, 16'h0100, 16'h0100, "pllAlarm");
    chk("alarmPin", {15'h0, alarmPin}, 16'h0001);
    pllLocked <= 1'b1;
    wr(ADDR_SHUTOFF, 16'h0002);
    for (i = 0; i < 4; i++) begin
      fifoRdPtr <= 8'h01 << i;
      soak(ADDR_STATUS, 16'h001F, fifoExp[i], "fifoDistance");
      if (i == 0) chk("outputsEnable", {15'h0, outputsEnable}, 16'h0000);
    end
    fifoWrPtr <= 8'h00;
    soak(ADDR_STATUS, 16'h001F, 16'h0001, "zeroPtr");
    fifoWrPtr <= 8'h01;
    fifoRdPtr <= 8'h10;
    wr(ADDR_SHUTOFF, 16'h0001);
    run <= 1'b0;
    sclkRun <= 1'b0;
    soak(ADDR_STATUS, 16'h1060, 16'h1060, "clockGone");
    chk("outputsEnable", {15'h0, outputsEnable}, 16'h0000);
    idle(4);
    endOfTest();
  end
endmodule
